// file: common/p34pf_pkg.sv
// Constants shared by the port 3 and port 4 pin-function select block.
package p34pf_pkg;

  // ==========================================================================
  // Bus and pin geometry
  localparam int ADDR_W = 16;
  localparam int NUM_REGS = 6;
  localparam int P3_PINS = 10;
  localparam int P4_PINS = 3;

  // ==========================================================================
  // Register indices; the byte address is four times the index.
  localparam logic [31:0] DIR3_INDEX = 32'hFFFFF426;
  localparam logic [31:0] ALT3_INDEX = 32'hFFFFF446;
  localparam logic [31:0] FSEL3_INDEX = 32'hFFFFF466;
  localparam logic [31:0] FEXT3_INDEX = 32'hFFFFF486;
  localparam logic [31:0] DRV3_INDEX = 32'h0FFFFC66;
  localparam logic [31:0] ALT4_INDEX = 32'hFFFFF448;

  // Slots of the register table below.
  localparam int REG_DIR3 = 0;
  localparam int REG_ALT3 = 1;
  localparam int REG_FSEL3 = 2;
  localparam int REG_FEXT3 = 3;
  localparam int REG_DRV3 = 4;
  localparam int REG_ALT4 = 5;

  // Word addresses of the whole register and of its high byte alias.
  localparam logic [ADDR_W-1:0] REG_LOW_ADDR [NUM_REGS] = '{
    ADDR_W'(DIR3_INDEX << 2), ADDR_W'(ALT3_INDEX << 2),
    ADDR_W'(FSEL3_INDEX << 2), ADDR_W'(FEXT3_INDEX << 2),
    ADDR_W'(DRV3_INDEX << 2), ADDR_W'(ALT4_INDEX << 2)};
  localparam logic [ADDR_W-1:0] REG_HIGH_ADDR [NUM_REGS] = '{
    ADDR_W'((DIR3_INDEX + 32'h1) << 2), ADDR_W'((ALT3_INDEX + 32'h1) << 2),
    ADDR_W'((FSEL3_INDEX + 32'h1) << 2), ADDR_W'(FEXT3_INDEX << 2),
    ADDR_W'((DRV3_INDEX + 32'h1) << 2), ADDR_W'(ALT4_INDEX << 2)};
  localparam logic [NUM_REGS-1:0] REG_HAS_HIGH = 6'h17;

  // Implemented bits, reset values and the value reserved bits read as.
  localparam logic [15:0] REG_MASK [NUM_REGS] = '{
    16'h03FF, 16'h033F, 16'h033F, 16'h0004, 16'h03FF, 16'h0007};
  localparam logic [15:0] REG_RESET [NUM_REGS] = '{
    16'hFFFF, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  localparam logic [15:0] REG_FILL [NUM_REGS] = '{
    16'hFC00, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

  // ==========================================================================
  // Field positions and idle levels
  localparam int PIN2_EXT_BIT = 2;
  localparam logic LINE_IDLE = 1'b1;
  localparam logic EDGE_IDLE = 1'b0;

endpackage

// file: hw/p34pf_split_reg.sv
// One port register reachable as a word and, optionally, as a high byte.
`timescale 1ns/10ps
module p34pf_split_reg #(
  parameter logic [15:0] MASK = 16'hFFFF,
  parameter logic [15:0] RESET = 16'h0000,
  parameter logic [15:0] FILL = 16'h0000,
  parameter bit HAS_HIGH = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_word,
  input wire logic wr_high,
  input wire logic [15:0] wdata,
  input wire logic [1:0] strb,
  output logic [15:0] value
);

  // ==========================================================================
  // Byte lane merge
  logic [15:0] store_q;
  logic [15:0] store_d;
  logic lo_en;
  logic hi_en;
  logic [7:0] hi_data;

  // A word access may touch either lane; the alias only reaches bits 15:8.
  assign lo_en = wr_word & strb[0];
  assign hi_en = HAS_HIGH & ((wr_word & strb[1]) | (wr_high & strb[0]));
  assign hi_data = wr_high ? wdata[7:0] : wdata[15:8];
  assign store_d = {hi_en ? hi_data : store_q[15:8],
                    lo_en ? wdata[7:0] : store_q[7:0]};

  // Only implemented bits are kept, so reserved bits cannot be set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      store_q <= RESET & MASK;
    end else begin
      store_q <= store_d & MASK;
    end
  end

  assign value = (store_q & MASK) | (FILL & ~MASK);

endmodule // p34pf_split_reg

// file: hw/p34pf_pad_driver.sv
// Output driver of one pad: port or alternate source, CMOS or open drain.
`timescale 1ns/10ps
module p34pf_pad_driver (
  input wire logic use_alt,
  input wire logic alt_out,
  input wire logic alt_oe,
  input wire logic port_out,
  input wire logic port_input_mode,
  input wire logic open_drain,
  output logic pad_out,
  output logic pad_oe
);

  // ==========================================================================
  // Source and driver selection
  logic src;
  logic drive;

  assign src = use_alt ? alt_out : port_out;
  assign drive = use_alt ? alt_oe : ~port_input_mode;
  assign pad_out = src;
  assign pad_oe = drive & (~open_drain | ~src);

endmodule // p34pf_pad_driver

// file: hw/p34pf_top.sv
// Port 3 and port 4 pin-function select with its APB register file.
//
// Behaviour
// - Function select: bits 9,8,5..0; rest zero
// - Word access, plus a high byte register
// - High byte register carries bits 15 to 8
// - Pin 9: UART2 receive or I2C0 clock
// - Pin 8: UART2 transmit or I2C0 data
// - Pins 5..3: timer capture in or output
// - Pin 2: two-bit select of four functions
// - Pin 1: UART0 receive plus interrupt, or serial4
// - Pin 0: UART0 transmit or serial4 data out
// - Driver select: CMOS or open drain per pin
// - Port 4 pins controlled one bit each
// - Port 4 pin 1: port or serial0 data out/I2C1 clock
// - Port 4 pin 0: port or serial0/I2C1 data
// - Direction bit 0 output, 1 input; resets ones
// - Mode bit 1 hands pin to alternate function
//
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
module p34pf_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [p34pf_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [p34pf_pkg::P3_PINS-1:0] port3_latch,
  input wire logic [p34pf_pkg::P4_PINS-1:0] port4_latch,
  input wire logic [p34pf_pkg::P4_PINS-1:0] port4_direction,
  input wire logic [p34pf_pkg::P4_PINS-1:0] port4_driver_type,
  input wire logic [1:0] port4_i2c_select,
  input wire logic [p34pf_pkg::P3_PINS-1:0] pad3_in,
  output logic [p34pf_pkg::P3_PINS-1:0] pad3_out,
  output logic [p34pf_pkg::P3_PINS-1:0] pad3_oe,
  input wire logic [p34pf_pkg::P4_PINS-1:0] pad4_in,
  output logic [p34pf_pkg::P4_PINS-1:0] pad4_out,
  output logic [p34pf_pkg::P4_PINS-1:0] pad4_oe,
  output logic uart2_receive_in,
  input wire logic uart2_transmit_out,
  output logic i2c0_clock_in,
  input wire logic i2c0_clock_out,
  input wire logic i2c0_clock_oe,
  output logic i2c0_data_in,
  input wire logic i2c0_data_out,
  input wire logic i2c0_data_oe,
  output logic timer_capture_in_11,
  output logic timer_capture_in_10,
  output logic timer_capture_in_01,
  output logic timer_capture_in_00,
  input wire logic timer_out_11,
  input wire logic timer_out_10,
  input wire logic timer_out_01,
  input wire logic timer_out_00,
  output logic uart0_baud_clock_in,
  output logic serial4_clock_in,
  input wire logic serial4_clock_out,
  input wire logic serial4_clock_oe,
  output logic uart0_receive_in,
  output logic external_interrupt_7,
  output logic serial4_data_in,
  input wire logic uart0_transmit_out,
  input wire logic serial4_data_out,
  output logic serial0_clock_in,
  input wire logic serial0_clock_out,
  input wire logic serial0_clock_oe,
  input wire logic serial0_data_out,
  output logic serial0_data_in,
  output logic i2c1_clock_in,
  input wire logic i2c1_clock_out,
  input wire logic i2c1_clock_oe,
  output logic i2c1_data_in,
  input wire logic i2c1_data_out,
  input wire logic i2c1_data_oe
);

  localparam int NREG = p34pf_pkg::NUM_REGS;
  localparam int N3 = p34pf_pkg::P3_PINS;
  localparam int N4 = p34pf_pkg::P4_PINS;

  // ==========================================================================
  // APB decode
  logic setup_phase;
  logic access_phase;
  logic [NREG-1:0] hit_word;
  logic [NREG-1:0] hit_high;
  logic mapped;
  logic [15:0] reg_value [NREG];
  logic [31:0] reg_rdata [NREG];
  logic [31:0] rdata_d;
  logic [31:0] prdata_q;

  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;

  for (genvar k = 0; k < NREG; k++) begin : g_reg
    assign hit_word[k] = paddr == p34pf_pkg::REG_LOW_ADDR[k];
    assign hit_high[k] = p34pf_pkg::REG_HAS_HIGH[k]
                         & (paddr == p34pf_pkg::REG_HIGH_ADDR[k]);
    assign reg_rdata[k] = hit_high[k] ? {24'h000000, reg_value[k][15:8]}
                        : hit_word[k] ? {16'h0000, reg_value[k]}
                        : 32'h00000000;

    // Writes land only at the access edge, matching the bus contract.
    p34pf_split_reg #(
      .MASK(p34pf_pkg::REG_MASK[k]),
      .RESET(p34pf_pkg::REG_RESET[k]),
      .FILL(p34pf_pkg::REG_FILL[k]),
      .HAS_HIGH(p34pf_pkg::REG_HAS_HIGH[k])
    ) u_reg (
      .pclk(pclk),
      .presetn(presetn),
      .wr_word(access_phase & pwrite & hit_word[k]),
      .wr_high(access_phase & pwrite & hit_high[k]),
      .wdata(pwdata[15:0]),
      .strb(pstrb[1:0]),
      .value(reg_value[k])
    );
  end

  assign mapped = |{hit_word, hit_high};

  // Zero wait states; unmapped addresses answer with an error.
  assign pready = 1'b1;
  assign pslverr = access_phase & ~mapped;

  // Merge the per-register read words; at most one is non-zero.
  always_comb begin
    rdata_d = 32'h00000000;
    for (int k = 0; k < NREG; k++) begin
      rdata_d = rdata_d | reg_rdata[k];
    end
  end

  // Read data is captured in the setup cycle so it is stable in access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (setup_phase & ~pwrite) begin
      prdata_q <= rdata_d;
    end
  end

  assign prdata = prdata_q;

  // ==========================================================================
  // Effective controls
  logic [N3-1:0] p3_dir;
  logic [N3-1:0] p3_alt;
  logic [N3-1:0] p3_sel;
  logic [N3-1:0] p3_od;
  logic p3_ext;
  logic [N4-1:0] p4_alt;
  logic [1:0] p2_mode;

  assign p3_dir = reg_value[p34pf_pkg::REG_DIR3][N3-1:0];
  assign p3_alt = reg_value[p34pf_pkg::REG_ALT3][N3-1:0];
  assign p3_sel = reg_value[p34pf_pkg::REG_FSEL3][N3-1:0] & p3_alt;
  assign p3_ext = reg_value[p34pf_pkg::REG_FEXT3][p34pf_pkg::PIN2_EXT_BIT]
                  & p3_alt[2];
  assign p3_od = reg_value[p34pf_pkg::REG_DRV3][N3-1:0];
  assign p4_alt = reg_value[p34pf_pkg::REG_ALT4][N4-1:0];
  assign p2_mode = {p3_ext, p3_sel[2]};

  // ==========================================================================
  // Port 3 alternate output sources
  logic [N3-1:0] alt3_out;
  logic [N3-1:0] alt3_oe;

  assign alt3_out[0] = p3_sel[0] ? serial4_data_out : uart0_transmit_out;
  assign alt3_oe[0] = 1'b1;
  // Pin 1 is input only in every alternate function.
  assign alt3_out[1] = 1'b0;
  assign alt3_oe[1] = 1'b0;
  assign alt3_out[2] = p2_mode[1] ? timer_out_00 : serial4_clock_out;
  assign alt3_oe[2] = (p2_mode == 2'h3)
                      | ((p2_mode == 2'h1) & serial4_clock_oe);
  assign alt3_out[3] = timer_out_01;
  assign alt3_oe[3] = p3_sel[3];
  assign alt3_out[4] = timer_out_10;
  assign alt3_oe[4] = p3_sel[4];
  assign alt3_out[5] = timer_out_11;
  assign alt3_oe[5] = p3_sel[5];
  // Pins 6 and 7 have no alternate function; their mode bits are unimplemented, so they stay port pins.
  assign alt3_out[7:6] = 2'h0;
  assign alt3_oe[7:6] = 2'h0;
  assign alt3_out[8] = p3_sel[8] ? i2c0_data_out : uart2_transmit_out;
  assign alt3_oe[8] = p3_sel[8] ? i2c0_data_oe : 1'b1;
  assign alt3_out[9] = i2c0_clock_out;
  assign alt3_oe[9] = p3_sel[9] & i2c0_clock_oe;

  // ==========================================================================
  // Port 3 inputs toward the peripherals
  // Unselected inputs sit at their idle level so no false edge or start
  // bit reaches a peripheral when software re-routes a pin.

  assign uart2_receive_in = (p3_alt[9] & ~p3_sel[9])
                            ? pad3_in[9] : p34pf_pkg::LINE_IDLE;
  assign i2c0_clock_in = p3_sel[9] ? pad3_in[9] : p34pf_pkg::LINE_IDLE;
  assign i2c0_data_in = p3_sel[8] ? pad3_in[8] : p34pf_pkg::LINE_IDLE;
  assign timer_capture_in_11 = (p3_alt[5] & ~p3_sel[5])
                               ? pad3_in[5] : p34pf_pkg::EDGE_IDLE;
  assign timer_capture_in_10 = (p3_alt[4] & ~p3_sel[4])
                               ? pad3_in[4] : p34pf_pkg::EDGE_IDLE;
  assign timer_capture_in_01 = (p3_alt[3] & ~p3_sel[3])
                               ? pad3_in[3] : p34pf_pkg::EDGE_IDLE;
  assign uart0_baud_clock_in = (p3_alt[2] & (p2_mode == 2'h0))
                               ? pad3_in[2] : p34pf_pkg::EDGE_IDLE;
  assign serial4_clock_in = (p2_mode == 2'h1)
                            ? pad3_in[2] : p34pf_pkg::LINE_IDLE;
  assign timer_capture_in_00 = (p2_mode == 2'h2)
                               ? pad3_in[2] : p34pf_pkg::EDGE_IDLE;
  assign uart0_receive_in = (p3_alt[1] & ~p3_sel[1])
                            ? pad3_in[1] : p34pf_pkg::LINE_IDLE;
  assign external_interrupt_7 = (p3_alt[1] & ~p3_sel[1])
                                ? pad3_in[1] : p34pf_pkg::EDGE_IDLE;
  assign serial4_data_in = p3_sel[1] ? pad3_in[1] : p34pf_pkg::LINE_IDLE;

  // ==========================================================================
  // Port 4 routing
  logic [N4-1:0] alt4_out;
  logic [N4-1:0] alt4_oe;

  // pin 0 data in or I2C1
  assign alt4_out[0] = i2c1_data_out;
  assign alt4_oe[0] = port4_i2c_select[0] & i2c1_data_oe;
  assign serial0_data_in = (p4_alt[0] & ~port4_i2c_select[0])
                           ? pad4_in[0] : p34pf_pkg::LINE_IDLE;
  assign i2c1_data_in = (p4_alt[0] & port4_i2c_select[0])
                        ? pad4_in[0] : p34pf_pkg::LINE_IDLE;
  // pin 1 data out or I2C1
  assign alt4_out[1] = port4_i2c_select[1] ? i2c1_clock_out
                       : serial0_data_out;
  assign alt4_oe[1] = port4_i2c_select[1] ? i2c1_clock_oe : 1'b1;
  assign i2c1_clock_in = (p4_alt[1] & port4_i2c_select[1])
                         ? pad4_in[1] : p34pf_pkg::LINE_IDLE;
  assign alt4_out[2] = serial0_clock_out;
  assign alt4_oe[2] = serial0_clock_oe;
  assign serial0_clock_in = p4_alt[2] ? pad4_in[2] : p34pf_pkg::LINE_IDLE;

  // ==========================================================================
  // Pad drivers
  // The driver-type bit applies in both port and alternate mode, which is
  // what makes the I2C lines wired-AND once software selects open drain.
  // open drain chosen by software
  for (genvar i = 0; i < N3; i++) begin : g_pad3
    p34pf_pad_driver u_drv (
      .use_alt(p3_alt[i]),
      .alt_out(alt3_out[i]),
      .alt_oe(alt3_oe[i]),
      .port_out(port3_latch[i]),
      .port_input_mode(p3_dir[i]),
      .open_drain(p3_od[i]),
      .pad_out(pad3_out[i]),
      .pad_oe(pad3_oe[i])
    );
  end

  for (genvar j = 0; j < N4; j++) begin : g_pad4
    p34pf_pad_driver u_drv (
      .use_alt(p4_alt[j]),
      .alt_out(alt4_out[j]),
      .alt_oe(alt4_oe[j]),
      .port_out(port4_latch[j]),
      .port_input_mode(port4_direction[j]),
      .open_drain(port4_driver_type[j]),
      .pad_out(pad4_out[j]),
      .pad_oe(pad4_oe[j])
    );
  end

endmodule // p34pf_top

// file: testbench/p34pf_assertions.sv
// Port-level checks for the pin-function select block.
`timescale 1ns/10ps
module p34pf_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [9:0] pad3_in,
  input wire logic [9:0] pad3_oe,
  input wire logic uart0_receive_in,
  input wire logic external_interrupt_7,
  input wire logic uart0_baud_clock_in,
  input wire logic timer_capture_in_00
);
  // ==========================================================================
  // Decode of read setups
  localparam logic [15:0] AD = p34pf_pkg::REG_LOW_ADDR[p34pf_pkg::REG_DIR3];
  localparam logic [15:0] AF = p34pf_pkg::REG_LOW_ADDR[p34pf_pkg::REG_FSEL3];
  localparam logic [15:0] AH = p34pf_pkg::REG_HIGH_ADDR[p34pf_pkg::REG_FSEL3];
  // Read data is loaded at the setup edge, so it is judged one cycle on.
  wire logic rd_go = psel && !penable && !pwrite;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ==========================================================================
  // Properties
  a_slverr_in_access: assert property (
    pslverr |-> psel && penable) else $error("error flag outside access");
  a_zero_wait: assert property (
    psel && !penable |=> pready) else $error("access phase not ready");
  a_fsel_reserved: assert property (
    rd_go && paddr == AF |=> prdata[31:10] == 22'h0 && prdata[7:6] == 2'h0)
    else $error("select register reserved bits not zero");
  a_high_alias: assert property (
    rd_go && paddr == AH |=> prdata[31:8] == 24'h0)
    else $error("high byte read wider than a byte");
  a_dir_fill: assert property (
    rd_go && paddr == AD |=> prdata[15:10] == 6'h3F)
    else $error("direction upper bits not ones");
  a_reset_pads_off: assert property (
    $rose(presetn) |-> pad3_oe == 10'h000)
    else $error("pad driven right after reset");
  a_irq_rx_pair: assert property (
    external_interrupt_7 |-> uart0_receive_in && pad3_in[1])
    else $error("interrupt 7 not shared with receive");
  a_pin2_one_fn: assert property (
    !(uart0_baud_clock_in && timer_capture_in_00))
    else $error("pin 2 routed to two inputs");
endmodule // p34pf_assertions

bind p34pf_top p34pf_assertions i_p34pf_assertions (.pclk, .presetn,
  .paddr, .psel, .penable, .pwrite, .prdata, .pready, .pslverr, .pad3_in,
  .pad3_oe, .uart0_receive_in, .external_interrupt_7, .uart0_baud_clock_in,
  .timer_capture_in_00);

// file: testbench/p34pf_periph_model.sv
// Behavioural peripherals on the far side of the pin-function block.
`timescale 1ns/10ps
module p34pf_periph_model (
  input wire logic [15:0] pat,
  output logic uart2_transmit_out,
  output logic i2c0_clock_out,
  output logic i2c0_clock_oe,
  output logic i2c0_data_out,
  output logic i2c0_data_oe,
  output logic timer_out_11,
  output logic timer_out_10,
  output logic timer_out_01,
  output logic timer_out_00,
  output logic serial4_clock_out,
  output logic serial4_clock_oe,
  output logic uart0_transmit_out,
  output logic serial4_data_out,
  output logic serial0_clock_out,
  output logic serial0_clock_oe,
  output logic serial0_data_out,
  output logic i2c1_clock_out,
  output logic i2c1_clock_oe,
  output logic i2c1_data_out,
  output logic i2c1_data_oe
);
  // ==========================================================================
  // Drives
  // open-drain pull-low
  // Bus lines only pull low, so the enable carries the data bit.
  assign {i2c0_clock_out, i2c0_data_out, i2c1_clock_out, i2c1_data_out} = 4'h0;
  // pushed outputs
  // Other levels follow the bench word, so each bit can take both values.
  assign {uart2_transmit_out, i2c0_clock_oe, i2c0_data_oe, timer_out_11,
    timer_out_10, timer_out_01, timer_out_00, serial4_clock_out,
    serial4_clock_oe, uart0_transmit_out, serial4_data_out, serial0_clock_out,
    serial0_clock_oe, serial0_data_out, i2c1_clock_oe, i2c1_data_oe} = pat;
endmodule // p34pf_periph_model

// file: testbench/tb_top.sv
// Self-checking bench for the port 3 and port 4 pin-function select.
`timescale 1ns/10ps
module tb_top;
  // ==========================================================================
  // Signals
  localparam logic [15:0] AD = p34pf_pkg::REG_LOW_ADDR[p34pf_pkg::REG_DIR3];
  localparam logic [15:0] AA = p34pf_pkg::REG_LOW_ADDR[p34pf_pkg::REG_ALT3];
  localparam logic [15:0] AF = p34pf_pkg::REG_LOW_ADDR[p34pf_pkg::REG_FSEL3];
  localparam logic [15:0] AE = p34pf_pkg::REG_LOW_ADDR[p34pf_pkg::REG_FEXT3];
  localparam logic [15:0] AO = p34pf_pkg::REG_LOW_ADDR[p34pf_pkg::REG_DRV3];
  localparam logic [15:0] A4 = p34pf_pkg::REG_LOW_ADDR[p34pf_pkg::REG_ALT4];
  localparam logic [15:0] AFH = p34pf_pkg::REG_HIGH_ADDR[p34pf_pkg::REG_FSEL3];
  localparam logic [15:0] RST_V [6] = '{16'hFFFF, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000};
  localparam logic [15:0] ONE_V [6] = '{16'hFFFF, 16'h033F, 16'h033F,
    16'h0004, 16'h03FF, 16'h0007};
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, pready, pslverr, slv;
  logic [15:0] paddr = 16'h0000, pat = 16'h0000;
  logic [31:0] pwdata = 32'h00000000, prdata, rdat;
  logic [3:0] pstrb = 4'h0;
  logic [9:0] port3_latch = 10'h000, ext3 = 10'h3FF, pad3_out, pad3_oe;
  logic [2:0] port4_latch = 3'h0, port4_direction = 3'h7, ext4 = 3'h7;
  logic [2:0] port4_driver_type = 3'h0, pad4_out, pad4_oe;
  logic [1:0] port4_i2c_select = 2'h0;
  logic uart2_receive_in, i2c0_clock_in, i2c0_data_in, uart0_baud_clock_in;
  logic timer_capture_in_11, timer_capture_in_10, timer_capture_in_01;
  logic timer_capture_in_00, serial4_clock_in, uart0_receive_in;
  logic external_interrupt_7, serial4_data_in, serial0_clock_in;
  logic serial0_data_in, i2c1_clock_in, i2c1_data_in;
  logic uart2_transmit_out, i2c0_clock_out, i2c0_clock_oe, i2c0_data_out;
  logic i2c0_data_oe, timer_out_11, timer_out_10, timer_out_01;
  logic timer_out_00, serial4_clock_out, serial4_clock_oe;
  logic uart0_transmit_out, serial4_data_out, serial0_clock_out;
  logic serial0_clock_oe, serial0_data_out, i2c1_clock_out, i2c1_clock_oe;
  logic i2c1_data_out, i2c1_data_oe;
  int n_errors = 0, checked = 0;
  // A driving pad shows its own level, an undriven one the outside level.
  wire logic [9:0] pad3_in = (pad3_oe & pad3_out) | (~pad3_oe & ext3);
  wire logic [2:0] pad4_in = (pad4_oe & pad4_out) | (~pad4_oe & ext4);

  p34pf_top i_p34pf_top (.*);
  p34pf_periph_model i_p34pf_periph_model (.*);

  // 10 MHz clock.
  always #50 pclk = ~pclk;

  // ==========================================================================
  // Tasks
  // Count a comparison and report it at once if it differs.
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the idle edge first keeps each drive once a step.
  task automatic xfer(input logic [15:0] a, input logic w,
    input logic [15:0] d, input logic [1:0] s);
    @(posedge pclk);
    psel <= 1'h1;
    paddr <= a;
    pwrite <= w;
    pwdata <= {16'h0000, d};
    pstrb <= {2'h0, s};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rdat = prdata;
    slv = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    xfer(a, 1'h1, d, 2'h3);
  endtask

  task automatic rd(input logic [15:0] a);
    xfer(a, 1'h0, 16'h0000, 2'h0);
  endtask

  // New far-side levels at a rising edge, looked at on the falling one.
  task automatic drive(input logic [15:0] p, input logic [9:0] e3);
    @(posedge pclk);
    pat <= p;
    ext3 <= e3;
    ext4 <= e3[2:0];
    @(negedge pclk);
  endtask

  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // The tests need under two hundred cycles; ten thousand means a hang.
  initial begin
    #1000000;
    n_errors++;
    complete_run();
  end

  // ==========================================================================
  // Tests
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 6; i++) begin
      rd(p34pf_pkg::REG_LOW_ADDR[i]);
      chk(rdat, {16'h0000, RST_V[i]});
      wr(p34pf_pkg::REG_LOW_ADDR[i], 16'hFFFF);
      rd(p34pf_pkg::REG_LOW_ADDR[i]);
      chk({slv, rdat}, {17'h0, ONE_V[i]});
    end
    xfer(AFH, 1'h1, 16'h0001, 2'h1);
    rd(AF);
    chk(rdat, 32'h0000013F);
    rd(AFH);
    chk(rdat, 32'h00000001);
    xfer(AO, 1'h1, 16'h0000, 2'h1);
    rd(AO);
    chk(rdat, 32'h00000300);
    wr(16'h0100, 16'hFFFF);
    rd(16'h0100);
    chk({slv, rdat}, {1'h1, 32'h0});
    $display("test registers done");
    wr(AD, 16'h0000);
    wr(AO, 16'h0000);
    wr(AA, 16'h033F);
    for (int k = 0; k < 2; k++) begin
      wr(AF, 16'h0000);
      wr(AE, 16'h0000);
      drive(k ? 16'h5A5A : 16'hA5A5, k ? 10'h2AA : 10'h155);
      chk({uart2_receive_in, pad3_oe[9]}, {pad3_in[9], 1'h0});
      chk({pad3_out[8], pad3_oe[8]}, {uart2_transmit_out, 1'h1});
      chk({timer_capture_in_11, timer_capture_in_10, timer_capture_in_01,
        pad3_oe[5:3]}, {pad3_in[5:3], 3'h0});
      chk(uart0_baud_clock_in, pad3_in[2]);
      // Software keeps only one pin 1 consumer enabled; both still see it.
      chk({uart0_receive_in, external_interrupt_7, serial4_data_in},
        {pad3_in[1], pad3_in[1], 1'h1});
      chk(pad3_out[0], uart0_transmit_out);
      wr(AF, 16'h033F);
      drive(pat, ext3);
      chk({i2c0_clock_in, pad3_oe[9], pad3_out[9], uart2_receive_in},
        {pad3_in[9], i2c0_clock_oe, 2'h1});
      chk({i2c0_data_in, pad3_oe[8]}, {pad3_in[8], i2c0_data_oe});
      chk({pad3_out[5:3], pad3_oe[5:3]},
        {timer_out_11, timer_out_10, timer_out_01, 3'h7});
      chk({serial4_clock_in, pad3_oe[2], pad3_out[2], uart0_baud_clock_in},
        {pad3_in[2], serial4_clock_oe, serial4_clock_out, 1'h0});
      chk({serial4_data_in, uart0_receive_in, external_interrupt_7},
        {pad3_in[1], 2'h2});
      chk(pad3_out[0], serial4_data_out);
      wr(AE, 16'h0004);
      drive(pat, ext3);
      chk({pad3_out[2], pad3_oe[2]}, {timer_out_00, 1'h1});
      wr(AF, 16'h033B);
      drive(pat, ext3);
      chk({timer_capture_in_00, pad3_oe[2], uart0_baud_clock_in},
        {pad3_in[2], 2'h0});
    end
    wr(AA, 16'h0000);
    wr(AD, 16'h03FF);
    drive(pat, ext3);
    chk({uart2_receive_in, i2c0_clock_in, timer_capture_in_11,
      external_interrupt_7, pad3_oe}, {4'hC, 10'h000});
    wr(AD, 16'h0000);
    port3_latch <= 10'h2AA;
    drive(pat, ext3);
    chk({pad3_oe, pad3_out}, {10'h3FF, 10'h2AA});
    wr(AO, 16'h03FF); // open drain as for a high pull-up
    drive(pat, ext3);
    chk({pad3_oe, pad3_out & pad3_oe}, {10'h155, 10'h000});
    $display("test port 3 routing done");
    wr(A4, 16'h0007);
    drive(pat, ext3);
    chk({pad4_out[2], pad4_oe[2], serial0_clock_in},
      {serial0_clock_out, serial0_clock_oe, pad4_in[2]});
    chk({pad4_out[1], pad4_oe[1:0], serial0_data_in},
      {serial0_data_out, 2'h2, pad4_in[0]});
    @(posedge pclk);
    port4_i2c_select <= 2'h3;
    drive(pat, ext3);
    chk({pad4_oe[1:0], pad4_out[1], i2c1_clock_in, i2c1_data_in},
      {i2c1_clock_oe, i2c1_data_oe, 1'h0, pad4_in[1:0]});
    wr(A4, 16'h0000);
    port4_direction <= 3'h0;
    port4_latch <= 3'h5;
    drive(pat, ext3);
    chk({pad4_oe, pad4_out}, {3'h7, 3'h5});
    // Open drain on port 4 releases every pin that would drive high.
    @(posedge pclk);
    port4_driver_type <= 3'h7;
    drive(pat, ext3);
    chk({pad4_oe, pad4_out & pad4_oe}, {3'h2, 3'h0});
    $display("test port 4 routing done");
    complete_run();
  end
endmodule // tb_top
